// [shared/line_irq_defines.vh]
// Purpose: register map, field positions, reset values and timing counts
// Assumes: APB with 32-bit data; printed offsets are register indices
// Notes:   byte address of a register is four times its index
`ifndef LINE_IRQ_DEFINES_VH
`define LINE_IRQ_DEFINES_VH

// Register indices as printed
`define IDX_MAINT_CTRL      8'h31
`define IDX_TERM_CFG        8'h32
`define IDX_LINE_IRQ_EN     8'h33
`define IDX_ERR_IRQ_EN      8'h34
`define IDX_EDGE_SEL        8'h35
`define IDX_STATUS_LIVE     8'h36
`define IDX_GAIN_STATUS     8'h37
`define IDX_LINE_PENDING    8'h3A
`define IDX_ERR_PENDING     8'h3B
`define IDX_CNT_HIGH        8'h3C
`define IDX_CNT_LOW         8'h3D

// Field positions
`define BIT_SNAP_TRIG       0
`define BIT_REPORT_MODE     1
`define BIT_LOS             0
`define BIT_DF              2

// Writable masks
`define MASK_MAINT          8'h03
`define MASK_TERM           8'h3F
`define MASK_LINE           8'h05
`define MASK_ERR            8'h77

// Reset values
`define RST_TERM_CFG        8'h07
`define RST_ZERO8           8'h00

// Impedance codes
`define TERM_75             3'h0
`define TERM_120            3'h1
`define TERM_100            3'h2
`define TERM_110            3'h3

// Auto report period: one second at 100 MHz
`define REPORT_PERIOD_NS    1000000000
`define CLK_PERIOD_NS       10
`define REPORT_CYCLES       (`REPORT_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// [rtl/line_status_irq.v]
// Purpose: status, interrupt and termination registers of one line unit
// Assumes: pclk at 100 MHz; line status inputs come from another domain
// Notes:   error event inputs are one-cycle pulses on pclk
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "line_irq_defines.vh"

// Function
// - Trigger acts only in manual report mode
// - Trigger rising edge copies counter to bytes
// - Decode transmit impedance; 1xx reserved
// - Receive impedance; 1xx selects external bypass
// - Driver fault and signal lost drive interrupt
// - Six error flags with matching enables
// - Disabled source still records, no interrupt
// - Edge select zero: rising edge only
// - Edge select one: both edges
// - Driver fault live status bit readable
// - Signal lost live status bit readable
// - Write one clears pending flag
// - Report mode zero selects manual reporting
// - Report mode one copies counter every second
// - Five-bit read-only line gain field
module line_status_irq #(
  parameter REPORT_CYCLES = `REPORT_CYCLES
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Line status from analog side, asynchronous
  input  wire        driver_fault_in,
  input  wire        signal_lost_in,
  input  wire [4:0]  line_gain_in,
  // Error event pulses, pclk domain
  input  wire        pulse_sum_evt,
  input  wire        tx_jitter_fifo_evt,
  input  wire        rx_jitter_fifo_evt,
  input  wire        zero_run_evt,
  input  wire        bipolar_violation_evt,
  input  wire        counter_overflow_evt,
  // Internal excessive-zero counter value
  input  wire [15:0] zero_run_count,
  // Termination selects
  output reg  [1:0]  tx_impedance_sel,
  output reg  [1:0]  rx_impedance_sel,
  output reg         rx_external_term,
  // Interrupt, active low
  output reg         irq_n
);

  // Register state
  // All mapped registers are eight bits wide; the bus upper bits
  // are ignored on write and read back as zero
  reg [7:0]  maint_q;        // Report mode and snapshot trigger
  reg [7:0]  term_q;         // Termination config
  reg [7:0]  line_en_q;      // Line interrupt enables
  reg [7:0]  err_en_q;       // Error interrupt enables
  reg [7:0]  edge_q;         // Edge selects
  reg [7:0]  line_pend_q;    // Line pending flags
  reg [7:0]  err_pend_q;     // Error pending flags
  reg [15:0] snap_q;         // Readable count bytes
  reg [31:0] sec_q;          // One second divider
  reg        trig_prev_q;    // Trigger delayed for edge detect

  // Synchronisers, three stages; 2nd and 3rd compared
  // A level is taken only once two stages agree, so a
  // metastable first stage never reaches the edge logic
  // Gain bits are settled as a group: a word still moving
  // between stages is simply not accepted yet
  reg [2:0]  df_sync_q;
  reg [2:0]  los_sync_q;
  reg [4:0]  gain_s1_q;      // First stage of gain only
  reg [4:0]  gain_s2_q;
  reg [4:0]  gain_s3_q;
  reg        df_live_q;      // Settled driver fault
  reg        los_live_q;     // Settled signal lost
  reg [4:0]  gain_q;         // Settled gain

  // APB decode
  // Access phase strobes; the slave never stretches an
  // access, so ready is not part of the write condition
  wire       wr_en  = psel & penable & pwrite;
  wire       rd_en  = psel & penable & ~pwrite;
  wire [9:0] idx    = paddr[11:2];
  wire [7:0] wbyte  = pwdata[7:0];
  reg        hit;            // Mapped address
  reg [7:0]  rbyte;          // Read mux

  // Edge and event terms
  // A change counts when the settled stage differs from
  // the live bit; the live bit follows one edge later,
  // so each settled change gives exactly one change pulse
  wire df_chg   = (df_sync_q[1] == df_sync_q[2]) &
                  (df_sync_q[2] != df_live_q);
  wire los_chg  = (los_sync_q[1] == los_sync_q[2]) &
                  (los_sync_q[2] != los_live_q);
  wire df_rise  = df_chg & df_sync_q[2];
  wire los_rise = los_chg & los_sync_q[2];
  wire df_set   = edge_q[`BIT_DF]  ? df_chg  : df_rise;
  wire los_set  = edge_q[`BIT_LOS] ? los_chg : los_rise;
  wire [7:0] line_set = {5'h00, df_set, 1'b0, los_set};
  wire [7:0] err_set  = {1'b0, pulse_sum_evt, tx_jitter_fifo_evt,
                         rx_jitter_fifo_evt, 1'b0, zero_run_evt,
                         bipolar_violation_evt, counter_overflow_evt};

  // Snapshot triggers
  // Trigger edge is seen against its own delayed copy, so
  // rewriting a one leaves the count bytes untouched
  // In auto mode the trigger is ignored; only the tick copies
  wire manual   = ~maint_q[`BIT_REPORT_MODE];
  wire trig_up  = maint_q[`BIT_SNAP_TRIG] & ~trig_prev_q;
  wire sec_tick = (sec_q == REPORT_CYCLES - 1);
  wire snap_now = manual ? trig_up : sec_tick;

  // Write strobes per register
  wire wr_line_pend = wr_en & (idx == {2'b00, `IDX_LINE_PENDING});
  wire wr_err_pend  = wr_en & (idx == {2'b00, `IDX_ERR_PENDING});
  wire [7:0] line_clr = wr_line_pend ? wbyte : 8'h00;
  wire [7:0] err_clr  = wr_err_pend  ? wbyte : 8'h00;

  // Address decode and read mux
  // Reads have no side effects: pending flags are cleared
  // only by writing ones, never by reading them
  always @* begin
    hit   = 1'b1;
    rbyte = 8'h00;
    if (idx == {2'b00, `IDX_MAINT_CTRL}) begin
      rbyte = maint_q;
    end else if (idx == {2'b00, `IDX_TERM_CFG}) begin
      rbyte = term_q;
    end else if (idx == {2'b00, `IDX_LINE_IRQ_EN}) begin
      rbyte = line_en_q;
    end else if (idx == {2'b00, `IDX_ERR_IRQ_EN}) begin
      rbyte = err_en_q;
    end else if (idx == {2'b00, `IDX_EDGE_SEL}) begin
      rbyte = edge_q;
    end else if (idx == {2'b00, `IDX_STATUS_LIVE}) begin
      // Live bits read straight from settled status
      rbyte = {5'h00, df_live_q, 1'b0, los_live_q};
    end else if (idx == {2'b00, `IDX_GAIN_STATUS}) begin
      rbyte = {3'h0, gain_q};
    end else if (idx == {2'b00, `IDX_LINE_PENDING}) begin
      rbyte = line_pend_q;
    end else if (idx == {2'b00, `IDX_ERR_PENDING}) begin
      rbyte = err_pend_q;
    end else if (idx == {2'b00, `IDX_CNT_HIGH}) begin
      rbyte = snap_q[15:8];
    end else if (idx == {2'b00, `IDX_CNT_LOW}) begin
      rbyte = snap_q[7:0];
    end else begin
      // Unmapped index answers with an error
      hit = 1'b0;
    end
  end

  // Synchronise line status inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      df_sync_q  <= 3'h0;
      los_sync_q <= 3'h0;
      gain_s1_q  <= 5'h00;
      gain_s2_q  <= 5'h00;
      gain_s3_q  <= 5'h00;
      df_live_q  <= 1'b0;
      los_live_q <= 1'b0;
      gain_q     <= 5'h00;
    end else begin
      df_sync_q  <= {df_sync_q[1:0], driver_fault_in};
      los_sync_q <= {los_sync_q[1:0], signal_lost_in};
      gain_s1_q  <= line_gain_in;
      gain_s2_q  <= gain_s1_q;
      gain_s3_q  <= gain_s2_q;
      // Accept only once two stages agree
      if (df_chg) begin
        df_live_q <= df_sync_q[2];
      end
      if (los_chg) begin
        los_live_q <= los_sync_q[2];
      end
      if (gain_s2_q == gain_s3_q) begin
        gain_q <= gain_s3_q;
      end
    end
  end

  // Control registers written by software
  // Reserved bits are masked on write and read back as zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maint_q   <= `RST_ZERO8;
      term_q    <= `RST_TERM_CFG;
      line_en_q <= `RST_ZERO8;
      err_en_q  <= `RST_ZERO8;
      edge_q    <= `RST_ZERO8;
    end else if (wr_en) begin
      if (idx == {2'b00, `IDX_MAINT_CTRL}) begin
        maint_q <= wbyte & `MASK_MAINT;
      end else if (idx == {2'b00, `IDX_TERM_CFG}) begin
        term_q <= wbyte & `MASK_TERM;
      end else if (idx == {2'b00, `IDX_LINE_IRQ_EN}) begin
        line_en_q <= wbyte & `MASK_LINE;
      end else if (idx == {2'b00, `IDX_ERR_IRQ_EN}) begin
        err_en_q <= wbyte & `MASK_ERR;
      end else if (idx == {2'b00, `IDX_EDGE_SEL}) begin
        edge_q <= wbyte & `MASK_LINE;
      end
    end
  end

  // Pending flags: set beats a same-cycle clear
  // An event landing in the clearing cycle must survive,
  // otherwise software could lose it without seeing it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_pend_q <= `RST_ZERO8;
      err_pend_q  <= `RST_ZERO8;
    end else begin
      // Flags record regardless of enables
      line_pend_q <= ((line_pend_q & ~line_clr) | line_set)
                     & `MASK_LINE;
      err_pend_q  <= ((err_pend_q & ~err_clr) | err_set)
                     & `MASK_ERR;
    end
  end

  // Counter snapshot, manual edge or one-second tick
  // The period counter is held at zero in manual mode, so
  // the first automatic copy comes one full period after
  // software selects automatic reporting
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_q <= 1'b0;
      sec_q       <= 32'h0000_0000;
      snap_q      <= 16'h0000;
    end else begin
      // Only a fresh rising edge fires again
      trig_prev_q <= maint_q[`BIT_SNAP_TRIG];
      if (manual || sec_tick) begin
        sec_q <= 32'h0000_0000;
      end else begin
        sec_q <= sec_q + 32'h0000_0001;
      end
      if (snap_now) begin
        snap_q <= zero_run_count;
      end
    end
  end

  // Termination decode; upper code bit handled separately
  // Transmit code sits in b5:b3, receive code in b2:b0
  // The transmit path has no external network, so a
  // reserved code cannot bypass anything; holding the last
  // valid choice keeps the line driver matched meanwhile
  // The receive upper bit is a bypass, not an impedance
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_impedance_sel <= 2'h0;
      rx_impedance_sel <= 2'h0;
      rx_external_term <= 1'b0;
    end else begin
      // Reserved transmit codes keep the last valid choice
      if (!term_q[5]) begin
        tx_impedance_sel <= term_q[4:3];
      end
      rx_impedance_sel <= term_q[1:0];
      rx_external_term <= term_q[2];
    end
  end

  // Interrupt output and APB answer
  // Enables only gate the pin; flags keep recording events
  // Read data is captured in setup so it stands in access
  // The pin is registered, one cycle behind the flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n   <= 1'b1;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      irq_n   <= ~(|(line_pend_q & line_en_q) |
                   |(err_pend_q & err_en_q));
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h000000, rbyte};
      end
    end
  end

endmodule

// [tb/line_status_irq_checker.sv]
// Purpose: port checks for line_status_irq
// Assumes: config mirrored from observed APB writes
// Notes:   bound below onto every instance
`timescale 1ns/1ps
module line_status_irq_checker #(
  parameter REPORT_CYCLES = 20
) (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Outputs watched
  input wire [1:0]  tx_impedance_sel,
  input wire [1:0]  rx_impedance_sel,
  input wire        rx_external_term,
  input wire        irq_n
);
  wire [9:0] idx = paddr[11:2];  // Word index
  wire map_ok = (idx >= 10'h031 && idx <= 10'h037) ||
                (idx >= 10'h03A && idx <= 10'h03D);
  wire wr_go = psel && penable && pready && pwrite;
  logic [7:0] term_q;     // Termination mirror
  logic [7:0] line_en_q;  // Line enable mirror
  logic [7:0] err_en_q;   // Error enable mirror
  // Mirrors lag nothing: updated at the write edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_q <= 8'h07;
      line_en_q <= 8'h00;
      err_en_q <= 8'h00;
    end else if (wr_go && idx == 10'h032) begin
      term_q <= pwdata[7:0];
    end else if (wr_go && idx == 10'h033) begin
      line_en_q <= pwdata[7:0] & 8'h05;
    end else if (wr_go && idx == 10'h034) begin
      err_en_q <= pwdata[7:0] & 8'h77;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_unmapped: assert property (psel && !penable && !map_ok |=> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (psel && !penable && map_ok |=> !pslverr)
    else $error("mapped access refused");
  chk_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_tx_term: assert property (
    wr_go && idx == 10'h032 && !pwdata[5] |=> ##1
      tx_impedance_sel == term_q[4:3])
    else $error("tx impedance wrong");
  chk_rx_term: assert property (
    wr_go && idx == 10'h032 |=> ##1 rx_external_term == term_q[2] &&
      (term_q[2] || rx_impedance_sel == term_q[1:0]))
    else $error("rx impedance wrong");
  chk_irq_quiet: assert property (
    line_en_q == 8'h00 && err_en_q == 8'h00 |=> irq_n)
    else $error("irq with all sources disabled");
endmodule
bind line_status_irq line_status_irq_checker #(
  .REPORT_CYCLES(REPORT_CYCLES)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_n(irq_n),
  .tx_impedance_sel(tx_impedance_sel), .rx_impedance_sel(rx_impedance_sel),
  .rx_external_term(rx_external_term)
);

// [tb/line_side_model.sv]
// Purpose: line side stand-in: levels, counter, error pulses
// Assumes: changes launched just after rising edges
// Notes:   evt bits follow the error pending layout
`timescale 1ns/1ps
module line_side_model (
  // Clock
  input  wire         pclk,
  // Levels and counter
  output logic        driver_fault_in,
  output logic        signal_lost_in,
  output logic [4:0]  line_gain_in,
  output logic [15:0] zero_run_count,
  // Error pulses
  output logic [6:0]  evt
);
  // Quiet line at start
  initial begin
    {driver_fault_in, signal_lost_in, line_gain_in} = 7'h00;
    zero_run_count = 16'h0000;
    evt = 7'h00;
  end
  // New line levels
  task automatic set_line(input logic df, input logic los,
                          input logic [4:0] g, input logic [15:0] c);
    @(posedge pclk);
    driver_fault_in <= df;
    signal_lost_in <= los;
    line_gain_in <= g;
    zero_run_count <= c;
  endtask
  // One-cycle pulse, bit b
  task automatic pulse(input int b);
    @(posedge pclk);
    evt <= 7'(1 << b);
    @(posedge pclk);
    evt <= 7'h00;
  endtask
endmodule

// [tb/tb_top.sv]
// Purpose: register level tests of line_status_irq
// Assumes: one wait-free APB slave; short report period
// Notes:   line levels need ~4 cycles through the sync
`timescale 1ns/1ps
`include "line_irq_defines.vh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_n, rx_ext, df, los;
  wire  [1:0]  tx_sel, rx_sel;
  wire  [4:0]  gain;
  wire  [15:0] cnt;
  wire  [6:0]  evt;
  logic [7:0]  rd;   // Last read byte
  logic        slv;  // Last error flag
  int          fail_count, checks, i;
  line_side_model u_line_side_model (.pclk(pclk), .driver_fault_in(df),
    .signal_lost_in(los), .line_gain_in(gain), .zero_run_count(cnt),
    .evt(evt));
  line_status_irq #(.REPORT_CYCLES(20)) u_line_status_irq (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .driver_fault_in(df), .signal_lost_in(los),
    .line_gain_in(gain), .pulse_sum_evt(evt[6]),
    .tx_jitter_fifo_evt(evt[5]), .rx_jitter_fifo_evt(evt[4]),
    .zero_run_evt(evt[2]), .bipolar_violation_evt(evt[1]),
    .counter_overflow_evt(evt[0]), .zero_run_count(cnt),
    .tx_impedance_sel(tx_sel), .rx_impedance_sel(rx_sel),
    .rx_external_term(rx_ext), .irq_n(irq_n));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for ready, bounded by the watchdog
  task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d);
  endtask
  task automatic rdc(input logic [7:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00);
    chk(rd, e);
  endtask
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`IDX_TERM_CFG, 8'h07);
    rdc(`IDX_ERR_IRQ_EN, 8'h00);
    rdc(8'h40, 8'h00);
    chk(slv, 1'b1);
    for (i = 0; i < 4; i++) begin
      wr(`IDX_TERM_CFG, {3'b000, i[1:0], 1'b0, i[1:0]});
      repeat (2) @(posedge pclk);
      chk({rx_ext, tx_sel, rx_sel}, {1'b0, i[1:0], i[1:0]});
    end
    wr(`IDX_TERM_CFG, 8'h04);
    repeat (2) @(posedge pclk);
    chk(rx_ext, 1'b1);
    wr(`IDX_TERM_CFG, 8'h3B);
    repeat (2) @(posedge pclk);
    chk({rx_ext, tx_sel, rx_sel}, {1'b0, 2'h0, 2'h3});
    rdc(`IDX_TERM_CFG, 8'h3B);
    // Each error source masked, then enabled, then cleared
    for (i = 0; i < 7; i++) if (i != 3) begin
      u_line_side_model.pulse(i);
      repeat (2) @(posedge pclk);
      chk(irq_n, 1'b1);
      rdc(`IDX_ERR_PENDING, 8'(1 << i));
      wr(`IDX_ERR_PENDING, 8'(1 << i));
      wr(`IDX_ERR_IRQ_EN, 8'(1 << i));
      u_line_side_model.pulse(i);
      repeat (2) @(posedge pclk);
      chk(irq_n, 1'b0);
      wr(`IDX_ERR_PENDING, 8'(1 << i));
      repeat (2) @(posedge pclk);
      chk(irq_n, 1'b1);
      wr(`IDX_ERR_IRQ_EN, 8'h00);
    end
    // Rising edge only, then both edges
    wr(`IDX_LINE_IRQ_EN, 8'h05);
    u_line_side_model.set_line(1'b0, 1'b1, 5'h15, 16'hA5C3);
    repeat (8) @(posedge pclk);
    rdc(`IDX_STATUS_LIVE, 8'h01);
    rdc(`IDX_GAIN_STATUS, 8'h15);
    rdc(`IDX_LINE_PENDING, 8'h01);
    chk(irq_n, 1'b0);
    wr(`IDX_LINE_PENDING, 8'h01);
    u_line_side_model.set_line(1'b0, 1'b0, 5'h15, 16'hA5C3);
    repeat (8) @(posedge pclk);
    rdc(`IDX_LINE_PENDING, 8'h00);
    wr(`IDX_EDGE_SEL, 8'h04);
    u_line_side_model.set_line(1'b1, 1'b0, 5'h15, 16'hA5C3);
    repeat (8) @(posedge pclk);
    rdc(`IDX_STATUS_LIVE, 8'h04);
    wr(`IDX_LINE_PENDING, 8'h04);
    u_line_side_model.set_line(1'b0, 1'b0, 5'h15, 16'hA5C3);
    repeat (8) @(posedge pclk);
    rdc(`IDX_LINE_PENDING, 8'h04);
    wr(`IDX_LINE_PENDING, 8'h00);
    rdc(`IDX_LINE_PENDING, 8'h04);
    // Manual snapshot needs a fresh rising trigger
    wr(`IDX_MAINT_CTRL, 8'h01);
    rdc(`IDX_CNT_HIGH, 8'hA5);
    u_line_side_model.set_line(1'b0, 1'b0, 5'h15, 16'h1234);
    wr(`IDX_MAINT_CTRL, 8'h01);
    rdc(`IDX_CNT_LOW, 8'hC3);
    wr(`IDX_MAINT_CTRL, 8'h00);
    wr(`IDX_MAINT_CTRL, 8'h01);
    rdc(`IDX_CNT_LOW, 8'h34);
    wr(`IDX_MAINT_CTRL, 8'h02);
    u_line_side_model.set_line(1'b0, 1'b0, 5'h15, 16'h5AC3);
    repeat (30) @(posedge pclk);
    rdc(`IDX_CNT_HIGH, 8'h5A);
    complete_run();
  end
endmodule
